//--- rtl/cbl_pkg.sv
package cbl_pkg;

  localparam int NUM_CH = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 8;

  // Channel role field encoding
  typedef enum logic [1:0] {
    MODE_INDEP  = 2'b00,
    MODE_REF    = 2'b01,
    MODE_FOLLOW = 2'b10
  } cbl_mode_type;

  // Register offsets, one 16-bit word each
  localparam logic [ADDR_W-1:0] OFF_CHSET0   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_WEIGHT0  = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_LTA_BETA = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_ACT_BETA = 8'h07;
  localparam logic [ADDR_W-1:0] OFF_MOT_BETA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SETTLE   = 8'h09;
  localparam logic [ADDR_W-1:0] OFF_SNAPDLY  = 8'h0A;
  localparam logic [ADDR_W-1:0] OFF_RELPCT   = 8'h0B;
  localparam logic [ADDR_W-1:0] OFF_MOTTHR   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MOTDEB   = 8'h0D;
  localparam logic [ADDR_W-1:0] OFF_MOTTMO   = 8'h0E;
  localparam logic [ADDR_W-1:0] OFF_INTMASK  = 8'h0F;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INTSTAT  = 8'h11;
  localparam logic [ADDR_W-1:0] OFF_LTA0     = 8'h12;
  localparam logic [ADDR_W-1:0] OFF_ACT0     = 8'h15;
  localparam logic [ADDR_W-1:0] OFF_MOT0     = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SNAP0    = 8'h1B;

  // Channel setup field positions
  localparam int CS_MODE_LSB = 0;
  localparam int CS_REF_LSB  = 2;
  localparam int CS_REL_BIT  = 4;
  localparam int CS_MOT_BIT  = 5;
  localparam int CS_MASK_LSB = 8;
  localparam int STAT_PT_LSB = 8;

  // Interrupt status layout: three groups of per-channel bits
  localparam int INT_W          = 9;
  localparam int INT_REL_LSB    = 0;
  localparam int INT_TMO_LSB    = 3;
  localparam int INT_MOTSET_LSB = 6;

  // Arithmetic scaling: 4096 for weight, 128 for release percentage
  localparam int WEIGHT_SHIFT = 12;
  localparam int PCT_SHIFT    = 7;

  // Reset values
  localparam logic [DATA_W-1:0] CHSET_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] WEIGHT_RST = 16'h1000;
  localparam logic [3:0]        BETA_RST   = 4'h4;
  localparam logic [DATA_W-1:0] THR_RST    = 16'h0010;
  localparam logic [DATA_W-1:0] DEB_RST    = 16'h0404;
  localparam logic [DATA_W-1:0] TMO_RST    = 16'h0100;
  localparam logic [CNT_W-1:0]  SNAPDLY_RST = 8'h08;
  localparam logic [CNT_W-1:0]  RELPCT_RST  = 8'h40;
  localparam logic [DATA_W-1:0] SAT_MAX    = 16'hFFFF;

endpackage : cbl_pkg

//--- rtl/cbl_ui_logic.sv
`timescale 1ns/10ps
`default_nettype none
module cbl_ui_logic (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       sampleValid,
  input  wire logic [cbl_pkg::DATA_W-1:0] countCh0,
  input  wire logic [cbl_pkg::DATA_W-1:0] countCh1,
  input  wire logic [cbl_pkg::DATA_W-1:0] countCh2,
  input  wire logic [cbl_pkg::NUM_CH-1:0] proxDet,
  input  wire logic [cbl_pkg::NUM_CH-1:0] touchDet,
  input  wire logic [cbl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [cbl_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [cbl_pkg::DATA_W-1:0] regRdata,
  output logic      [cbl_pkg::NUM_CH-1:0] proxState,
  output logic      [cbl_pkg::NUM_CH-1:0] touchState,
  output logic      [cbl_pkg::NUM_CH-1:0] motionState,
  output logic      [cbl_pkg::NUM_CH-1:0] tuneInhibit,
  output logic      [cbl_pkg::NUM_CH-1:0] reseedPulse,
  output logic                            irq
);

  localparam int NCH = cbl_pkg::NUM_CH;
  localparam int DW  = cbl_pkg::DATA_W;
  localparam int CW  = cbl_pkg::CNT_W;
  localparam int IW  = cbl_pkg::INT_W;

  // Clamp a wide signed value into the unsigned baseline range
  function automatic logic [DW-1:0] sat16(input logic signed [22:0] v);
    logic [DW-1:0] r;
    if (v < 0) begin
      r = '0;
    end else if (v > $signed({7'h00, cbl_pkg::SAT_MAX})) begin
      r = cbl_pkg::SAT_MAX;
    end else begin
      r = v[DW-1:0];
    end
    return r;
  endfunction : sat16

  // Software settings
  logic [DW-1:0]   chSetQ [NCH];
  logic [DW-1:0]   weightQ [NCH];
  logic [3:0]      ltaBetaQ;
  logic [3:0]      actBetaQ;
  logic [3:0]      motBetaQ;
  logic [DW-1:0]   settleThrQ;
  logic [CW-1:0]   snapDelayQ;
  logic [CW-1:0]   relPctQ;
  logic [DW-1:0]   motThrQ;
  logic [DW-1:0]   motDebQ;
  logic [DW-1:0]   motTmoQ;
  logic [IW-1:0]   intMaskQ;
  logic [IW-1:0]   intStatQ;
  logic [IW-1:0]   intStatD;
  logic            irqQ;
  logic [DW-1:0]   rdDataQ;
  logic [DW-1:0]   rdMux;

  // Per-channel views shared between channels and the read mux
  logic [DW-1:0]        countArr [NCH];
  logic [DW-1:0]        ltaArr [NCH];
  logic [DW-1:0]        actArr [NCH];
  logic [DW-1:0]        motArr [NCH];
  logic [DW-1:0]        snapArr [NCH];
  logic signed [DW:0]   refStepArr [4];
  logic                 isRefArr [4];
  wire  [NCH-1:0]       proxVec;
  wire  [NCH-1:0]       touchVec;
  wire  [NCH-1:0]       motVec;
  wire  [NCH-1:0]       tuneVec;
  wire  [NCH-1:0]       reseedVec;
  wire  [NCH-1:0]       relEv;
  wire  [NCH-1:0]       tmoEv;
  wire  [NCH-1:0]       motSetEv;
  wire  [2*NCH-1:0]     ptStatus;
  wire  [IW-1:0]        intEv;
  wire                  rdIntStat;
  wire                  wrLtaBeta;
  wire                  wrActBeta;
  wire                  wrMotBeta;
  wire                  wrSettle;
  wire                  wrSnapDly;
  wire                  wrRelPct;
  wire                  wrMotThr;
  wire                  wrMotDeb;
  wire                  wrMotTmo;
  wire                  wrIntMask;

  assign countArr[0] = countCh0;
  assign countArr[1] = countCh1;
  assign countArr[2] = countCh2;

  // Unused fourth selector slot reads as a non-reference with no step
  assign refStepArr[3] = '0;
  assign isRefArr[3]   = 1'b0;

  // Global register write decode
  assign wrLtaBeta = regWr && (regAddr == cbl_pkg::OFF_LTA_BETA);
  assign wrActBeta = regWr && (regAddr == cbl_pkg::OFF_ACT_BETA);
  assign wrMotBeta = regWr && (regAddr == cbl_pkg::OFF_MOT_BETA);
  assign wrSettle  = regWr && (regAddr == cbl_pkg::OFF_SETTLE);
  assign wrSnapDly = regWr && (regAddr == cbl_pkg::OFF_SNAPDLY);
  assign wrRelPct  = regWr && (regAddr == cbl_pkg::OFF_RELPCT);
  assign wrMotThr  = regWr && (regAddr == cbl_pkg::OFF_MOTTHR);
  assign wrMotDeb  = regWr && (regAddr == cbl_pkg::OFF_MOTDEB);
  assign wrMotTmo  = regWr && (regAddr == cbl_pkg::OFF_MOTTMO);
  assign wrIntMask = regWr && (regAddr == cbl_pkg::OFF_INTMASK);
  assign rdIntStat = regRd && (regAddr == cbl_pkg::OFF_INTSTAT);

  // Upper status byte: proximity at bit 2n, touch at bit 2n+1
  genvar s;
  for (s = 0; s < NCH; s++) begin : gPt
    assign ptStatus[2*s]   = proxVec[s];
    assign ptStatus[2*s+1] = touchVec[s];
  end

  // Settings registers; per-channel words are written in one loop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        chSetQ[i]  <= cbl_pkg::CHSET_RST;
        weightQ[i] <= cbl_pkg::WEIGHT_RST;
      end
    end else if (regWr) begin
      for (int i = 0; i < NCH; i++) begin
        if (regAddr == 8'(cbl_pkg::OFF_CHSET0 + i)) begin
          chSetQ[i] <= regWdata;
        end
        if (regAddr == 8'(cbl_pkg::OFF_WEIGHT0 + i)) begin
          weightQ[i] <= regWdata;
        end
      end
    end
  end

  // Shared filter and threshold settings
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ltaBetaQ   <= cbl_pkg::BETA_RST;
      actBetaQ   <= cbl_pkg::BETA_RST;
      motBetaQ   <= cbl_pkg::BETA_RST;
      settleThrQ <= cbl_pkg::THR_RST;
      snapDelayQ <= cbl_pkg::SNAPDLY_RST;
      relPctQ    <= cbl_pkg::RELPCT_RST;
      motThrQ    <= cbl_pkg::THR_RST;
      motDebQ    <= cbl_pkg::DEB_RST;
      motTmoQ    <= cbl_pkg::TMO_RST;
      intMaskQ   <= '0;
    end else begin
      if (wrLtaBeta) ltaBetaQ <= regWdata[3:0];
      if (wrActBeta) actBetaQ <= regWdata[3:0];
      if (wrMotBeta) motBetaQ <= regWdata[3:0];
      if (wrSettle) settleThrQ <= regWdata;
      if (wrSnapDly) snapDelayQ <= regWdata[CW-1:0];
      if (wrRelPct) relPctQ <= regWdata[CW-1:0];
      if (wrMotThr) motThrQ <= regWdata;
      if (wrMotDeb) motDebQ <= regWdata;
      if (wrMotTmo) motTmoQ <= regWdata;
      if (wrIntMask) intMaskQ <= regWdata[IW-1:0];
    end
  end

  // Per-channel baseline engines
  genvar g;
  for (g = 0; g < NCH; g++) begin : gChan
    logic [DW-1:0]           ltaQ, actQ, motLtaQ, snapQ, tmoCntQ;
    logic [CW-1:0]           settleCntQ, entCntQ, exitCntQ;
    logic                    proxQ, touchQ, proxPrevQ, touchPrevQ;
    logic                    motStatQ, reseedQ, tuneQ;
    logic [DW-1:0]           cnt, ltaD, absLta, tmoNext;
    cbl_pkg::cbl_mode_type   mode;
    logic [1:0]              refSel;
    logic                    relOn, motOn, frozen, refOk, settled;
    logic                    relHit, tmoHit, above, below, setMot, clrMot, reseed;
    logic [7:0]              evMask;
    logic signed [DW:0]      diffLta, stepLta, actDiff, actStep, motDiff, motStep, refStep;
    logic [DW:0]             absAct, absMot;
    logic signed [33:0]      trackProd;
    logic signed [22:0]      trackAdj;
    logic [23:0]             relLimit;
    logic [CW-1:0]           settleNext, entNext, exitNext;

    assign cnt    = countArr[g];
    assign mode   = cbl_pkg::cbl_mode_type'(chSetQ[g][cbl_pkg::CS_MODE_LSB +: 2]);
    assign refSel = chSetQ[g][cbl_pkg::CS_REF_LSB +: 2];
    assign relOn  = chSetQ[g][cbl_pkg::CS_REL_BIT];
    assign motOn  = chSetQ[g][cbl_pkg::CS_MOT_BIT];
    assign evMask = chSetQ[g][cbl_pkg::CS_MASK_LSB +: 8];
    assign frozen = proxQ | touchQ;

    // Normal baseline filter step; a frozen channel takes no step
    assign diffLta = $signed({1'b0, cnt}) - $signed({1'b0, ltaQ});
    assign stepLta = diffLta >>> ltaBetaQ;
    assign refStepArr[g] = frozen ? '0 : stepLta;
    assign isRefArr[g]   = (mode == cbl_pkg::MODE_REF);

    // Selector counts only for followers and only when it names a reference channel
    assign refOk   = (mode == cbl_pkg::MODE_FOLLOW) && (refSel != 2'(g)) && isRefArr[refSel];
    assign refStep = refStepArr[refSel];
    assign trackProd = 34'(refStep) * $signed({18'h00000, weightQ[g]});
    assign trackAdj  = 23'(trackProd >>> cbl_pkg::WEIGHT_SHIFT);

    // Next normal baseline: reseed, follower tracking while frozen, hold while frozen, or filter
    always_comb begin
      if (reseed) begin
        ltaD = cnt;
      end else if (frozen && refOk) begin
        ltaD = sat16($signed({7'h00, ltaQ}) - trackAdj);
      end else if (frozen) begin
        ltaD = ltaQ;
      end else begin
        ltaD = sat16($signed({7'h00, ltaQ}) + 23'(stepLta));
      end
    end

    // Release: activation baseline, settling count and release threshold
    assign actDiff    = $signed({1'b0, cnt}) - $signed({1'b0, actQ});
    assign actStep    = actDiff >>> actBetaQ;
    assign absAct     = (actDiff < 0) ? 17'(-actDiff) : 17'(actDiff);
    assign absLta     = (diffLta < 0) ? 16'(-diffLta) : 16'(diffLta);
    assign settled    = absAct < {1'b0, settleThrQ};
    assign settleNext = (settleCntQ == '1) ? settleCntQ : settleCntQ + 8'h01;
    assign relLimit   = (24'(snapQ) * 24'(relPctQ)) >> cbl_pkg::PCT_SHIFT;
    assign relHit     = relOn && frozen && (25'(actDiff) > $signed({1'b0, relLimit}));

    // Motion: difference against motion baseline with two debounce counts
    assign motDiff  = $signed({1'b0, cnt}) - $signed({1'b0, motLtaQ});
    assign motStep  = motDiff >>> motBetaQ;
    assign absMot   = (motDiff < 0) ? 17'(-motDiff) : 17'(motDiff);
    assign above    = absMot > {1'b0, motThrQ};
    assign below    = absMot < {1'b0, motThrQ};
    assign entNext  = (entCntQ == '1) ? entCntQ : entCntQ + 8'h01;
    assign exitNext = (exitCntQ == '1) ? exitCntQ : exitCntQ + 8'h01;
    assign setMot   = motOn && above && (entNext > motDebQ[7:0]);
    assign clrMot   = motOn && below && (exitNext > motDebQ[15:8]);
    assign tmoNext  = (tmoCntQ == '1) ? tmoCntQ : tmoCntQ + 16'h0001;
    assign tmoHit   = motOn && !motStatQ && (tmoNext > motTmoQ);

    assign reseed = sampleValid && (relHit || tmoHit);

    // Sample-rate state update; idle cycles hold everything
    always_ff @(posedge clk) begin
      if (!nrst) begin
        ltaQ <= '0;
        actQ <= '0;
        motLtaQ <= '0;
        snapQ <= '0;
        settleCntQ <= '0;
        entCntQ <= '0;
        exitCntQ <= '0;
        tmoCntQ <= '0;
      end else if (sampleValid) begin
        ltaQ <= ltaD;
        // Activation baseline filtered every sample while release is on, regardless of touch; with release off it loads the count
        actQ <= relOn ? 16'($signed({1'b0, actQ}) + actStep) : cnt;
        settleCntQ <= (relOn && settled) ? settleNext : '0;
        // Snapshot refreshed each settled sample past the delay, only in an event
        if (relOn && frozen && settled && (settleNext > snapDelayQ)) snapQ <= absLta;
        motLtaQ <= motOn ? 16'($signed({1'b0, motLtaQ}) + motStep) : cnt;
        entCntQ <= (motOn && above) ? entNext : '0;
        exitCntQ <= (motOn && below) ? exitNext : '0;
        tmoCntQ <= (motOn && !motStatQ && !tmoHit) ? tmoNext : '0;
      end
    end

    // Event state, motion flag, reseed strobe and tuning block
    always_ff @(posedge clk) begin
      if (!nrst) begin
        proxQ <= 1'b0;
        touchQ <= 1'b0;
        proxPrevQ <= 1'b0;
        touchPrevQ <= 1'b0;
        motStatQ <= 1'b0;
        reseedQ <= 1'b0;
        tuneQ <= 1'b0;
      end else begin
        reseedQ <= reseed;
        tuneQ <= isRefArr[g] && |(evMask & {2'b00, ptStatus});
        if (sampleValid) begin
          proxPrevQ <= proxDet[g];
          touchPrevQ <= touchDet[g];
          // A reseeded channel re-enters only on a fresh detection edge
          proxQ <= !reseed && proxDet[g] && (proxQ || !proxPrevQ);
          touchQ <= !reseed && touchDet[g] && (touchQ || !touchPrevQ);
          if (!motOn) motStatQ <= 1'b0;
          else if (setMot) motStatQ <= 1'b1;
          else if (clrMot) motStatQ <= 1'b0;
        end
      end
    end

    assign ltaArr[g]    = ltaQ;
    assign actArr[g]    = actQ;
    assign motArr[g]    = motLtaQ;
    assign snapArr[g]   = snapQ;
    assign proxVec[g]   = proxQ;
    assign touchVec[g]  = touchQ;
    assign motVec[g]    = motStatQ;
    assign tuneVec[g]   = tuneQ;
    assign reseedVec[g] = reseedQ;
    assign relEv[g]     = sampleValid && relHit;
    assign tmoEv[g]     = sampleValid && tmoHit;
    assign motSetEv[g]  = sampleValid && setMot && !motStatQ;
  end

  // Sticky interrupt status; a new event beats the read-clear in the same cycle
  assign intEv    = {motSetEv, tmoEv, relEv};
  assign intStatD = (rdIntStat ? '0 : intStatQ) | intEv;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      intStatQ <= '0;
      irqQ <= 1'b0;
    end else begin
      intStatQ <= intStatD;
      irqQ <= |(intStatD & intMaskQ);
    end
  end

  // Read selection; unmapped addresses return zero
  always_comb begin
    rdMux = '0;
    case (regAddr)
      cbl_pkg::OFF_LTA_BETA: rdMux = {12'h000, ltaBetaQ};
      cbl_pkg::OFF_ACT_BETA: rdMux = {12'h000, actBetaQ};
      cbl_pkg::OFF_MOT_BETA: rdMux = {12'h000, motBetaQ};
      cbl_pkg::OFF_SETTLE:   rdMux = settleThrQ;
      cbl_pkg::OFF_SNAPDLY:  rdMux = {8'h00, snapDelayQ};
      cbl_pkg::OFF_RELPCT:   rdMux = {8'h00, relPctQ};
      cbl_pkg::OFF_MOTTHR:   rdMux = motThrQ;
      cbl_pkg::OFF_MOTDEB:   rdMux = motDebQ;
      cbl_pkg::OFF_MOTTMO:   rdMux = motTmoQ;
      cbl_pkg::OFF_INTMASK:  rdMux = {7'h00, intMaskQ};
      cbl_pkg::OFF_STATUS:   rdMux = {2'b00, ptStatus, 5'h00, motVec};
      cbl_pkg::OFF_INTSTAT:  rdMux = {7'h00, intStatQ};
      default:               rdMux = '0;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (regAddr == 8'(cbl_pkg::OFF_CHSET0 + i)) rdMux = chSetQ[i];
      if (regAddr == 8'(cbl_pkg::OFF_WEIGHT0 + i)) rdMux = weightQ[i];
      if (regAddr == 8'(cbl_pkg::OFF_LTA0 + i)) rdMux = ltaArr[i];
      if (regAddr == 8'(cbl_pkg::OFF_ACT0 + i)) rdMux = actArr[i];
      if (regAddr == 8'(cbl_pkg::OFF_MOT0 + i)) rdMux = motArr[i];
      if (regAddr == 8'(cbl_pkg::OFF_SNAP0 + i)) rdMux = snapArr[i];
    end
  end

  // Read data valid only the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdDataQ <= '0;
    end else begin
      rdDataQ <= regRd ? rdMux : '0;
    end
  end

  assign regRdata    = rdDataQ;
  assign proxState   = proxVec;
  assign touchState  = touchVec;
  assign motionState = motVec;
  assign tuneInhibit = tuneVec;
  assign reseedPulse = reseedVec;
  assign irq         = irqQ;

endmodule : cbl_ui_logic
`default_nettype wire

//--- sim/cbl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cbl_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       sampleValid,
  input wire logic [2:0] proxDet,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [2:0] proxState,
  input wire logic [2:0] touchState,
  input wire logic [2:0] motionState,
  input wire logic [2:0] tuneInhibit,
  input wire logic [2:0] reseedPulse,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // States move only on a sample edge, so register traffic cannot disturb them
  prox_hold_a: assert property (!$past(sampleValid) |-> $stable(proxState) && $stable(touchState))
    else $error("state moved without a sample");
  motion_hold_a: assert property (!$past(sampleValid) |-> $stable(motionState))
    else $error("motion moved without a sample");
  reseed_clear_a: assert property (|reseedPulse |-> ((proxState | touchState) & reseedPulse) == 3'h0)
    else $error("state survived a reseed");
  reseed_cause_a: assert property (|reseedPulse |-> $past(sampleValid))
    else $error("reseed without a sample");
  reseed_once_a: assert property (|reseedPulse && !sampleValid |=> reseedPulse == 3'h0)
    else $error("reseed pulse too long");
  prox_cause_a: assert property ((proxState & ~$past(proxState) & ~$past(proxDet)) == 3'h0)
    else $error("proximity entered without detection");
  tune_idle_a: assert property (($past(proxState | touchState) == 3'h0) && ((proxState | touchState) == 3'h0)
    |-> tuneInhibit == 3'h0)
    else $error("tuning blocked with no state set");
  // A mask write reaches the interrupt pin one cycle after the mask register takes it
  irq_rise_a: assert property ($rose(irq) |-> $past(sampleValid) || $past(regWr, 2))
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(regRd) || $past(regWr, 2))
    else $error("interrupt fell without access");
endmodule : cbl_monitor
bind cbl_ui_logic cbl_monitor mon (.clk(clk), .nrst(nrst), .sampleValid(sampleValid), .proxDet(proxDet),
  .regWr(regWr), .regRd(regRd), .proxState(proxState), .touchState(touchState), .motionState(motionState),
  .tuneInhibit(tuneInhibit), .reseedPulse(reseedPulse), .irq(irq));
`default_nettype wire

//--- sim/cbl_front_model.sv
`timescale 1ns/10ps
`default_nettype none
module cbl_front_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] lvl0,
  input  wire logic [15:0] lvl1,
  input  wire logic [15:0] lvl2,
  output logic             sampleValid,
  output logic [15:0]      countCh0,
  output logic [15:0]      countCh1,
  output logic [15:0]      countCh2
);
  logic [1:0] phase_q;
  // One conversion every four cycles
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  // Counts are only meaningful with the strobe; otherwise show garbage
  assign sampleValid = nrst && (phase_q == 2'h3);
  assign countCh0 = sampleValid ? lvl0 : ~lvl0;
  assign countCh1 = sampleValid ? lvl1 : ~lvl1;
  assign countCh2 = sampleValid ? lvl2 : ~lvl2;
endmodule : cbl_front_model
`default_nettype wire

//--- sim/cbl_ui_logic_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cbl_ui_logic_tb;
  logic        clk, nrst, regWr, regRd, sampleValid, irq;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, rv, lvl0, lvl1, lvl2, countCh0, countCh1, countCh2;
  logic [2:0]  proxDet, touchDet, proxState, touchState, motionState, tuneInhibit, reseedPulse;
  int          err_count, compares, cyc, n;
  cbl_front_model fe (.clk(clk), .nrst(nrst), .lvl0(lvl0), .lvl1(lvl1), .lvl2(lvl2), .sampleValid(sampleValid),
    .countCh0(countCh0), .countCh1(countCh1), .countCh2(countCh2));
  cbl_ui_logic DUT (.clk(clk), .nrst(nrst), .sampleValid(sampleValid), .countCh0(countCh0), .countCh1(countCh1),
    .countCh2(countCh2), .proxDet(proxDet), .touchDet(touchDet), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .proxState(proxState), .touchState(touchState),
    .motionState(motionState), .tuneInhibit(tuneInhibit), .reseedPulse(reseedPulse), .irq(irq));
  // Free running clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask : rd
  task automatic smp(input int k);
    repeat (k) @(posedge clk iff sampleValid);
    #1;
  endtask : smp
  task automatic t_release;
    wr(cbl_pkg::OFF_LTA_BETA, 16'h0000);
    wr(cbl_pkg::OFF_ACT_BETA, 16'h0001);
    wr(cbl_pkg::OFF_INTMASK, 16'h01FF);
    wr(cbl_pkg::OFF_CHSET0, 16'h0010);
    smp(4);
    proxDet <= 3'h1;
    touchDet <= 3'h1;
    // Detection lands first; counts fall below the activation baseline so no early release
    smp(1);
    lvl0 <= 16'h0320;
    smp(19);
    chk(proxState, 16'h0001);
    chk(touchState, 16'h0001);
    rd(cbl_pkg::OFF_LTA0); chk(rv, 16'h03E8);
    rd(cbl_pkg::OFF_ACT0); chk(rv, 16'h0320);
    rd(cbl_pkg::OFF_SNAP0); chk(rv, 16'h00C8);
    lvl0 <= 16'h05DC;
    smp(1);
    chk(reseedPulse, 16'h0001);
    chk(proxState, 16'h0000);
    chk(touchState, 16'h0000);
    rd(cbl_pkg::OFF_LTA0); chk(rv, 16'h05DC);
    chk(irq, 16'h0001);
    rd(cbl_pkg::OFF_INTSTAT); chk(rv, 16'h0001);
    rd(cbl_pkg::OFF_INTSTAT); chk(rv, 16'h0000);
    chk(irq, 16'h0000);
    proxDet <= 3'h0;
    touchDet <= 3'h0;
    smp(2);
    $display("release test done");
  endtask : t_release
  // Motion set, clear, masked interrupt and timeout reseed on channel 1
  task automatic t_motion;
    wr(cbl_pkg::OFF_INTMASK, 16'h0000);
    wr(cbl_pkg::OFF_CHSET0 + 8'h01, 16'h0020); // Motion on; release off, mode left independent
    proxDet <= 3'h2;
    smp(4);
    lvl1 <= 16'h07D0;
    for (n = 0; n < 20 && motionState[1] !== 1'b1; n++) smp(1);
    chk(16'(n), 16'h0005);
    chk(proxState, 16'h0002);
    wr(cbl_pkg::OFF_MOTTMO, 16'h0010);
    chk(irq, 16'h0000);
    wr(cbl_pkg::OFF_INTMASK, 16'h01FF);
    @(posedge clk);
    #1 chk(irq, 16'h0001);
    rd(cbl_pkg::OFF_INTSTAT); chk(rv, 16'h0080);
    for (n = 0; n < 200 && motionState[1] !== 1'b0; n++) smp(1);
    chk(motionState, 16'h0000);
    for (n = 0; n < 40 && reseedPulse[1] !== 1'b1; n++) smp(1);
    chk(16'(n >= 15 && n <= 18), 16'h0001);
    chk(proxState, 16'h0000);
    rd(cbl_pkg::OFF_INTSTAT); chk(rv, 16'h0010);
    wr(cbl_pkg::OFF_CHSET0 + 8'h01, 16'h0000);
    proxDet <= 3'h0;
    lvl1 <= 16'h03E8;
    smp(8);
    chk(motionState, 16'h0000);
    $display("motion test done");
  endtask : t_motion
  // Channel 2 follows reference channel 0 at double weight
  task automatic t_follow;
    wr(cbl_pkg::OFF_CHSET0, 16'h3001);
    wr(cbl_pkg::OFF_CHSET0 + 8'h02, 16'h0002);
    wr(cbl_pkg::OFF_WEIGHT0 + 8'h02, 16'h2000);
    lvl0 <= 16'h03E8;
    lvl2 <= 16'h0BB8;
    smp(3);
    // Look right after the reference step; the unfrozen follower must ignore it and keep its own filter
    lvl0 <= 16'h03ED;
    smp(1);
    rd(cbl_pkg::OFF_LTA0 + 8'h02); chk(rv, 16'h0BB8);
    proxDet <= 3'h4;
    smp(2);
    chk(tuneInhibit, 16'h0001);
    lvl0 <= 16'h03F7;
    smp(1);
    rd(cbl_pkg::OFF_LTA0 + 8'h02); chk(rv, 16'h0BA4);
    proxDet <= 3'h0;
    smp(2);
    chk(tuneInhibit, 16'h0000);
    $display("follower test done");
  endtask : t_follow
  task automatic conclude;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // Reset, then the scenarios in turn
  initial begin
    {nrst, regWr, regRd, regAddr, regWdata, proxDet, touchDet} = '0;
    {lvl0, lvl1, lvl2} = {3{16'h03E8}};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(cbl_pkg::OFF_WEIGHT0); chk(rv, 16'h1000);
    rd(8'hFF); chk(rv, 16'h0000);
    t_release();
    t_motion();
    t_follow();
    conclude();
  end
endmodule : cbl_ui_logic_tb
`default_nettype wire
